/* File: hw/ctd_pkg.sv */
// Package for the coherent transaction type decoder: codes, types, constants
package ctd_pkg;

   // Barrier field codes
   localparam logic [1:0] CTD_BAR_NORM_RESP = 2'h0;
   localparam logic [1:0] CTD_BAR_MEMORY    = 2'h1;
   localparam logic [1:0] CTD_BAR_NORM_IGN  = 2'h2;
   localparam logic [1:0] CTD_BAR_SYNC      = 2'h3;

   // Shareability domain codes
   localparam logic [1:0] CTD_DOM_NSH = 2'h0;
   localparam logic [1:0] CTD_DOM_ISH = 2'h1;
   localparam logic [1:0] CTD_DOM_OSH = 2'h2;
   localparam logic [1:0] CTD_DOM_SYS = 2'h3;

   // Read snoop-type codes
   localparam logic [3:0] CTD_RS_PLAIN    = 4'h0;
   localparam logic [3:0] CTD_RS_SHARED   = 4'h1;
   localparam logic [3:0] CTD_RS_CLEAN    = 4'h2;
   localparam logic [3:0] CTD_RS_NSD      = 4'h3;
   localparam logic [3:0] CTD_RS_UNIQUE   = 4'h7;
   localparam logic [3:0] CTD_RS_CLN_SHR  = 4'h8;
   localparam logic [3:0] CTD_RS_CLN_INV  = 4'h9;
   localparam logic [3:0] CTD_RS_CLN_UNQ  = 4'hB;
   localparam logic [3:0] CTD_RS_MK_UNQ   = 4'hC;
   localparam logic [3:0] CTD_RS_MK_INV   = 4'hD;
   localparam logic [3:0] CTD_RS_DVM_CMPL = 4'hE;
   localparam logic [3:0] CTD_RS_DVM_MSG  = 4'hF;

   // Write snoop-type codes
   localparam logic [2:0] CTD_WS_PLAIN    = 3'h0;
   localparam logic [2:0] CTD_WS_LINE_UNQ = 3'h1;
   localparam logic [2:0] CTD_WS_CLEAN    = 3'h2;
   localparam logic [2:0] CTD_WS_COPYBACK = 3'h3;
   localparam logic [2:0] CTD_WS_EVICT    = 3'h4;
   localparam logic [2:0] CTD_WS_WR_EVICT = 3'h5;

   // Values after reset, and the illegal-count ceiling
   localparam logic [3:0] CTD_RST_EPOCH = 4'h0;
   localparam logic [7:0] CTD_RST_ICNT  = 8'h00;
   localparam logic [7:0] CTD_ICNT_MAX  = 8'hFF;

   typedef enum logic [2:0] {
      CTD_GRP_NONE, CTD_GRP_NOSNP, CTD_GRP_COH, CTD_GRP_MEMUPD,
      CTD_GRP_CMO, CTD_GRP_BAR, CTD_GRP_DVM
   } ctd_grp_e;

   typedef enum logic [4:0] {
      CTD_T_NONE, CTD_T_RD_NOSNP, CTD_T_RD_ONCE, CTD_T_RD_SHARED,
      CTD_T_RD_CLEAN, CTD_T_RD_NSD, CTD_T_RD_UNIQUE, CTD_T_CLN_UNQ,
      CTD_T_MK_UNQ, CTD_T_CLN_SHR, CTD_T_CLN_INV, CTD_T_MK_INV,
      CTD_T_BARRIER, CTD_T_DVM_CMPL, CTD_T_DVM_MSG, CTD_T_WR_NOSNP,
      CTD_T_WR_UNIQUE, CTD_T_WR_LINE_UNQ, CTD_T_WR_CLEAN,
      CTD_T_WR_COPYBACK, CTD_T_EVICT, CTD_T_WR_EVICT
   } ctd_typ_e;

   typedef struct packed {
      logic [1:0] bar;
      logic [1:0] domain;
      logic [3:0] snoop;
      logic [3:0] cache;
   } ctd_ar_s;

   typedef struct packed {
      logic [1:0] bar;
      logic [1:0] domain;
      logic [2:0] snoop;
      logic [3:0] cache;
   } ctd_aw_s;

   typedef struct packed {
      ctd_grp_e grp;
      ctd_typ_e typ;
      logic     illegal;
      logic     snoop_inner;
      logic     snoop_outer;
      logic     downstream;
      logic     cache_lookup;
      logic     bar_sync;
      logic     ign_bar;
      logic     attr_err;
   } ctd_dec_s;

   typedef struct packed {
      logic       vld;
      ctd_dec_s   dec;
      logic [3:0] epoch;
   } ctd_res_s;

   function automatic logic ctd_shareable(input logic [1:0] dom);
      ctd_shareable = (dom == CTD_DOM_ISH) || (dom == CTD_DOM_OSH);
   endfunction

endpackage

/* File: hw/ctd_dec.sv */
// Combinational classifier for one address-channel request
`timescale 1ns/1ps
module ctd_dec
   import ctd_pkg::*;
#(
   parameter bit RD = 1'b1
) (
   // Request fields
   input  wire logic [1:0] bar,
   input  wire logic [1:0] domain,
   input  wire logic [3:0] snoop,
   input  wire logic [3:0] cache,
   // Classification
   output ctd_dec_s        dec
);

   logic sh;
   logic nsys;

   assign sh   = ctd_shareable(domain);
   assign nsys = (domain != CTD_DOM_SYS);

   always_comb begin
      dec         = '0;
      dec.grp     = CTD_GRP_NONE;
      dec.typ     = CTD_T_NONE;
      dec.illegal = 1'h1;
      if (bar[0]) begin
         // Barrier: any domain, snoop-type all zero
         if (snoop == CTD_RS_PLAIN) begin
            dec.grp = CTD_GRP_BAR;
            dec.typ = CTD_T_BARRIER;
         end
      end else if (RD) begin
         case (snoop)
            CTD_RS_PLAIN: begin
               dec.grp = sh ? CTD_GRP_COH : CTD_GRP_NOSNP;
               dec.typ = sh ? CTD_T_RD_ONCE : CTD_T_RD_NOSNP;
            end
            CTD_RS_SHARED:   dec.typ = sh ? CTD_T_RD_SHARED : CTD_T_NONE;
            CTD_RS_CLEAN:    dec.typ = sh ? CTD_T_RD_CLEAN : CTD_T_NONE;
            CTD_RS_NSD:      dec.typ = sh ? CTD_T_RD_NSD : CTD_T_NONE;
            CTD_RS_UNIQUE:   dec.typ = sh ? CTD_T_RD_UNIQUE : CTD_T_NONE;
            CTD_RS_CLN_UNQ:  dec.typ = sh ? CTD_T_CLN_UNQ : CTD_T_NONE;
            CTD_RS_MK_UNQ:   dec.typ = sh ? CTD_T_MK_UNQ : CTD_T_NONE;
            CTD_RS_CLN_SHR:  dec.typ = nsys ? CTD_T_CLN_SHR : CTD_T_NONE;
            CTD_RS_CLN_INV:  dec.typ = nsys ? CTD_T_CLN_INV : CTD_T_NONE;
            CTD_RS_MK_INV:   dec.typ = nsys ? CTD_T_MK_INV : CTD_T_NONE;
            CTD_RS_DVM_CMPL: dec.typ = sh ? CTD_T_DVM_CMPL : CTD_T_NONE;
            CTD_RS_DVM_MSG:  dec.typ = sh ? CTD_T_DVM_MSG : CTD_T_NONE;
            default:         dec.typ = CTD_T_NONE;
         endcase
      end else begin
         case (snoop)
            {1'h0, CTD_WS_PLAIN}: begin
               dec.grp = sh ? CTD_GRP_COH : CTD_GRP_NOSNP;
               dec.typ = sh ? CTD_T_WR_UNIQUE : CTD_T_WR_NOSNP;
            end
            {1'h0, CTD_WS_LINE_UNQ}:
               dec.typ = sh ? CTD_T_WR_LINE_UNQ : CTD_T_NONE;
            {1'h0, CTD_WS_CLEAN}:
               dec.typ = nsys ? CTD_T_WR_CLEAN : CTD_T_NONE;
            {1'h0, CTD_WS_COPYBACK}:
               dec.typ = nsys ? CTD_T_WR_COPYBACK : CTD_T_NONE;
            {1'h0, CTD_WS_EVICT}:
               dec.typ = sh ? CTD_T_EVICT : CTD_T_NONE;
            {1'h0, CTD_WS_WR_EVICT}:
               dec.typ = nsys ? CTD_T_WR_EVICT : CTD_T_NONE;
            default: dec.typ = CTD_T_NONE;
         endcase
      end
      case (dec.typ)
         CTD_T_NONE:       dec.grp = CTD_GRP_NONE;
         CTD_T_RD_NOSNP, CTD_T_WR_NOSNP: dec.grp = CTD_GRP_NOSNP;
         CTD_T_CLN_SHR, CTD_T_CLN_INV, CTD_T_MK_INV: dec.grp = CTD_GRP_CMO;
         CTD_T_WR_CLEAN, CTD_T_WR_COPYBACK, CTD_T_EVICT, CTD_T_WR_EVICT:
            dec.grp = CTD_GRP_MEMUPD;
         CTD_T_BARRIER:    dec.grp = CTD_GRP_BAR;
         CTD_T_DVM_CMPL, CTD_T_DVM_MSG: dec.grp = CTD_GRP_DVM;
         default:          dec.grp = CTD_GRP_COH;
      endcase
      dec.illegal = (dec.typ == CTD_T_NONE);
      // Only coherent and maintenance requests reach peers
      if ((dec.grp == CTD_GRP_COH) || (dec.grp == CTD_GRP_CMO)) begin
         dec.snoop_inner = sh;
         dec.snoop_outer = (domain == CTD_DOM_OSH);
      end
      dec.downstream   = (dec.grp == CTD_GRP_CMO) ||
                         (dec.grp == CTD_GRP_MEMUPD);
      dec.cache_lookup = nsys && !dec.illegal &&
                         (dec.grp != CTD_GRP_BAR);
      dec.bar_sync     = (bar == CTD_BAR_SYNC);
      dec.ign_bar      = (bar == CTD_BAR_NORM_IGN);
      dec.attr_err     = (!cache[1] && nsys) ||
                         ((cache[3:2] != 2'h0) && !nsys);
   end

endmodule

/* File: hw/ctd_top.sv */
// Coherent transaction type decoder for the read and write address channels
// Summary of operation
// - Barrier codes: respect, memory, ignore, sync
// - Read snoop-type four bits, write three
// - Non-snooping requests never snoop peers
// - Memory updates go downstream without snooping
// - Coherent requests, and maintenance requests in inner or outer, snoop peers
// - Barriers order the requests around them
// - Plain read: non-shareable or system, zero
// - Shareable read with zero code is read-once
// - Coherent read codes in inner or outer
// - Maintenance reads: clean-shared, clean-invalid, make-invalid
// - Read barrier: low bit set, code zero
// - DVM completion and message on read channel
// - Plain write: non-shareable or system, zero
// - Shareable writes: partial or full-line unique
// - Memory-update write codes and allowed domains
// - Write barrier: low bit set, code zero
// - Outer snoop scope includes inner peer caches
// - System domain is never looked up
// - Domain codes: non, inner, outer, system
// - Bus clock and single active-low reset
`timescale 1ns/1ps
module ctd_top
   import ctd_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rstn,
   // Read address channel
   input  wire logic ar_valid,
   input  ctd_ar_s   ar_req,
   output logic      ar_ready,
   // Write address channel
   input  wire logic aw_valid,
   input  ctd_aw_s   aw_req,
   output logic      aw_ready,
   // Classification results
   output ctd_res_s  ar_res,
   output ctd_res_s  aw_res,
   output logic      ar_illegal,
   output logic      aw_illegal,
   output logic [7:0] ill_count
);

   typedef struct packed {
      logic       ar_rdy;
      logic       aw_rdy;
      ctd_res_s   ar_res;
      ctd_res_s   aw_res;
      logic       ar_ill;
      logic       aw_ill;
      logic [3:0] ar_epoch;
      logic [3:0] aw_epoch;
      logic [7:0] icnt;
   } ctd_state_s;

   ctd_state_s st_r;
   ctd_state_s st_nxt;
   ctd_dec_s   ar_dec;
   ctd_dec_s   aw_dec;
   logic       ar_acc;
   logic       aw_acc;
   logic [1:0] ill_inc;

   ctd_dec #(
      .RD     (1'b1)
   ) u_ar_dec (
      .bar    (ar_req.bar),
      .domain (ar_req.domain),
      .snoop  (ar_req.snoop),
      .cache  (ar_req.cache),
      .dec    (ar_dec)
   );

   // Write code widened; the top bit is always zero
   ctd_dec #(
      .RD     (1'b0)
   ) u_aw_dec (
      .bar    (aw_req.bar),
      .domain (aw_req.domain),
      .snoop  ({1'h0, aw_req.snoop}),
      .cache  (aw_req.cache),
      .dec    (aw_dec)
   );

   assign ar_acc  = ar_valid && st_r.ar_rdy;
   assign aw_acc  = aw_valid && st_r.aw_rdy;
   assign ill_inc = {1'h0, ar_acc && ar_dec.illegal} +
                    {1'h0, aw_acc && aw_dec.illegal};

   always_comb begin
      st_nxt        = st_r;
      // Decoder never stalls; ready rises the cycle after reset
      st_nxt.ar_rdy = 1'h1;
      st_nxt.aw_rdy = 1'h1;
      st_nxt.ar_res.vld = 1'h0;
      st_nxt.aw_res.vld = 1'h0;
      st_nxt.ar_ill = 1'h0;
      st_nxt.aw_ill = 1'h0;
      if (ar_acc) begin
         st_nxt.ar_res.vld   = 1'h1;
         st_nxt.ar_res.dec   = ar_dec;
         // A barrier closes its epoch; later requests carry the next one
         st_nxt.ar_res.epoch = st_r.ar_epoch;
         if (ar_dec.grp == CTD_GRP_BAR) begin
            st_nxt.ar_epoch = st_r.ar_epoch + 4'h1;
         end
         st_nxt.ar_ill = ar_dec.illegal;
      end
      if (aw_acc) begin
         st_nxt.aw_res.vld   = 1'h1;
         st_nxt.aw_res.dec   = aw_dec;
         st_nxt.aw_res.epoch = st_r.aw_epoch;
         if (aw_dec.grp == CTD_GRP_BAR) begin
            st_nxt.aw_epoch = st_r.aw_epoch + 4'h1;
         end
         st_nxt.aw_ill = aw_dec.illegal;
      end
      // Saturates so a stuck master cannot wrap it back to zero
      if ({1'h0, st_r.icnt} + {7'h00, ill_inc} > {1'h0, CTD_ICNT_MAX}) begin
         st_nxt.icnt = CTD_ICNT_MAX;
      end else begin
         st_nxt.icnt = st_r.icnt + {6'h00, ill_inc};
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_r          <= '0;
         st_r.ar_epoch <= CTD_RST_EPOCH;
         st_r.aw_epoch <= CTD_RST_EPOCH;
         st_r.icnt     <= CTD_RST_ICNT;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign ar_ready   = st_r.ar_rdy;
   assign aw_ready   = st_r.aw_rdy;
   assign ar_res     = st_r.ar_res;
   assign aw_res     = st_r.aw_res;
   assign ar_illegal = st_r.ar_ill;
   assign aw_illegal = st_r.aw_ill;
   assign ill_count  = st_r.icnt;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   sequence s_ar_take(logic [3:0] sn);
      ar_acc && !ar_req.bar[0] && ctd_shareable(ar_req.domain) &&
         (ar_req.snoop == sn);
   endsequence

   sequence s_aw_take(logic [2:0] sn);
      aw_acc && !aw_req.bar[0] && (aw_req.snoop == sn);
   endsequence

   sequence s_ar_out(ctd_typ_e t);
      ar_res.vld && (ar_res.dec.typ == t) && !ar_illegal;
   endsequence

   sequence s_aw_out(ctd_typ_e t);
      aw_res.vld && (aw_res.dec.typ == t) && !aw_illegal;
   endsequence

   a_rd_nosnoop: assert property (
      (ar_acc && !ar_req.bar[0] && !ctd_shareable(ar_req.domain) &&
       ar_req.snoop == CTD_RS_PLAIN) |=> s_ar_out(CTD_T_RD_NOSNP))
      else $error("plain read not decoded as non-snooping");

   a_rd_once: assert property (
      s_ar_take(CTD_RS_PLAIN) |=> s_ar_out(CTD_T_RD_ONCE))
      else $error("shareable zero read not decoded as read-once");

   a_rd_unique: assert property (
      s_ar_take(CTD_RS_UNIQUE) |=> s_ar_out(CTD_T_RD_UNIQUE) and
      (ar_res.dec.grp == CTD_GRP_COH))
      else $error("unique read misdecoded");

   a_rd_mkinv: assert property (
      (ar_acc && !ar_req.bar[0] && ar_req.domain != CTD_DOM_SYS &&
       ar_req.snoop == CTD_RS_MK_INV) |=>
      s_ar_out(CTD_T_MK_INV) and ar_res.dec.downstream)
      else $error("make-invalid misdecoded");

   a_rd_barrier: assert property (
      (ar_acc && ar_req.bar[0] && ar_req.snoop == CTD_RS_PLAIN) |=>
      s_ar_out(CTD_T_BARRIER))
      else $error("read barrier misdecoded");

   a_rd_dvm: assert property (
      s_ar_take(CTD_RS_DVM_MSG) |=> s_ar_out(CTD_T_DVM_MSG))
      else $error("dvm message misdecoded");

   a_rd_reserved: assert property (
      (ar_acc && ar_req.snoop == 4'h4) |=>
      ar_illegal ##1 (ar_illegal == $past(ar_acc && ar_dec.illegal)))
      else $error("reserved read code not flagged as a pulse");

   a_wr_nosnoop: assert property (
      (s_aw_take(CTD_WS_PLAIN) and !ctd_shareable(aw_req.domain)) |=>
      s_aw_out(CTD_T_WR_NOSNP))
      else $error("plain write not decoded as non-snooping");

   a_wr_unique: assert property (
      (s_aw_take(CTD_WS_LINE_UNQ) and ctd_shareable(aw_req.domain)) |=>
      s_aw_out(CTD_T_WR_LINE_UNQ))
      else $error("full-line unique write misdecoded");

   a_wr_evict_dom: assert property (
      (s_aw_take(CTD_WS_EVICT) and aw_req.domain == CTD_DOM_NSH) |=>
      aw_illegal && aw_res.vld)
      else $error("non-shareable eviction notice not flagged");

   a_wr_barrier: assert property (
      (aw_acc && aw_req.bar[0] && aw_req.snoop == CTD_WS_PLAIN) |=>
      s_aw_out(CTD_T_BARRIER))
      else $error("write barrier misdecoded");

   a_no_snoop_grp: assert property (
      (aw_res.vld && (aw_res.dec.grp == CTD_GRP_NOSNP ||
       aw_res.dec.grp == CTD_GRP_MEMUPD)) |->
      !aw_res.dec.snoop_inner && !aw_res.dec.snoop_outer)
      else $error("non-snooping or update write snoops peers");

   a_coh_snoops: assert property (
      s_ar_take(CTD_RS_SHARED) |=> ar_res.dec.snoop_inner)
      else $error("coherent read does not snoop peers");

   a_outer_incl: assert property (
      (ar_acc && ar_req.domain == CTD_DOM_OSH && !ar_dec.illegal &&
       ar_dec.grp == CTD_GRP_COH) |=>
      ar_res.dec.snoop_outer && ar_res.dec.snoop_inner)
      else $error("outer snoop scope misses inner peers");

   a_sys_nolookup: assert property (
      (aw_acc && aw_req.domain == CTD_DOM_SYS) |=>
      aw_res.vld && !aw_res.dec.cache_lookup)
      else $error("system domain request looked up in cache");

   a_epoch_step: assert property (
      (ar_acc && ar_req.bar[0] && ar_req.snoop == CTD_RS_PLAIN) ##1
      (ar_valid && ar_ready)[*2] |=>
      ar_res.epoch == $past(ar_res.epoch, 2) + 4'h1)
      else $error("request after read barrier kept the old epoch");

   a_sync_flag: assert property (
      (aw_acc && aw_req.bar == CTD_BAR_SYNC) |=> aw_res.dec.bar_sync)
      else $error("synchronization barrier not marked");

   a_ready_up: assert property (
      $rose(rstn) |-> ##[0:2] (ar_ready && aw_ready))
      else $error("ready not raised after reset");

   a_rd_clean: assert property (
      s_ar_take(CTD_RS_CLEAN)
      |=> s_ar_out(CTD_T_RD_CLEAN))
      else $error("clean read misdecoded");

   a_rd_nsd: assert property (
      s_ar_take(CTD_RS_NSD)
      |=> s_ar_out(CTD_T_RD_NSD))
      else $error("not-shared-dirty read misdecoded");

   a_rd_clnunq: assert property (
      s_ar_take(CTD_RS_CLN_UNQ)
      |=> s_ar_out(CTD_T_CLN_UNQ))
      else $error("clean-unique misdecoded");

   a_rd_mkunq: assert property (
      s_ar_take(CTD_RS_MK_UNQ)
      |=> s_ar_out(CTD_T_MK_UNQ))
      else $error("make-unique misdecoded");

   a_dvm_cmpl: assert property (
      s_ar_take(CTD_RS_DVM_CMPL)
      |=> s_ar_out(CTD_T_DVM_CMPL))
      else $error("dvm completion misdecoded");

   a_rd_clnshr: assert property (
      s_ar_take(CTD_RS_CLN_SHR)
      |=> s_ar_out(CTD_T_CLN_SHR))
      else $error("clean-shared misdecoded");

   a_ign_flag: assert property (
      (ar_acc &&
       ar_req.bar == CTD_BAR_NORM_IGN)
      |=> ar_res.dec.ign_bar)
      else $error("ignore-barrier access not marked");

   a_wr_partial: assert property (
      (s_aw_take(CTD_WS_PLAIN) and
       ctd_shareable(aw_req.domain))
      |=> s_aw_out(CTD_T_WR_UNIQUE))
      else $error("partial unique write misdecoded");

   a_wr_copyback: assert property (
      (s_aw_take(CTD_WS_COPYBACK) and
       aw_req.domain != CTD_DOM_SYS)
      |=> s_aw_out(CTD_T_WR_COPYBACK))
      else $error("copy-back write misdecoded");

   a_wr_evict: assert property (
      (s_aw_take(CTD_WS_WR_EVICT) and
       aw_req.domain == CTD_DOM_NSH)
      |=> s_aw_out(CTD_T_WR_EVICT))
      else $error("evicting write misdecoded");

   a_upd_down: assert property (
      (aw_res.vld &&
       aw_res.dec.grp == CTD_GRP_MEMUPD)
      |-> aw_res.dec.downstream)
      else $error("memory update not passed downstream");

   a_rd_nopeer: assert property (
      (ar_res.vld &&
       ar_res.dec.grp == CTD_GRP_NOSNP)
      |-> !ar_res.dec.snoop_inner && !ar_res.dec.snoop_outer)
      else $error("non-snooping read snoops peers");

   a_ill_pulse: assert property (
      ar_illegal
      |-> ar_res.vld && ar_res.dec.typ == CTD_T_NONE)
      else $error("illegal flag without an illegal result");

   a_ill_step: assert property (
      (ar_acc && ar_dec.illegal && !aw_acc &&
       ill_count != CTD_ICNT_MAX)
      |=> ill_count == $past(ill_count) + 8'h01)
      else $error("illegal count did not step by one");

   a_wr_epoch: assert property (
      (aw_acc && aw_dec.grp == CTD_GRP_BAR) ##1 aw_acc
      |=> aw_res.epoch == $past(aw_res.epoch) + 4'h1)
      else $error("request after write barrier kept the old epoch");

endmodule

/* File: verif/ctd_master.sv */
// Far-side master model driving the read and write address channels
`timescale 1ns/1ps
module ctd_master
   import ctd_pkg::*;
(
   // Clock
   input  wire logic clk_sys,
   // Read address channel
   output logic      ar_valid,
   output ctd_ar_s   ar_req,
   input  wire logic ar_ready,
   // Write address channel
   output logic      aw_valid,
   output ctd_aw_s   aw_req,
   input  wire logic aw_ready
);
   initial begin
      ar_valid = 1'b0;
      ar_req   = '0;
      aw_valid = 1'b0;
      aw_req   = '0;
   end

   // Caller sits on a rising edge; hold keeps valid up for a follow-on
   // Codes only as commanded, reserved ones too
   task automatic rd(input ctd_ar_s r, input bit hold);
      ar_valid <= 1'b1;
      ar_req   <= r;
      do @(posedge clk_sys); while (ar_ready !== 1'b1);
      if (!hold) begin
         ar_valid <= 1'b0;
         // Released fields never keep the last value
         ar_req   <= ~r;
      end
   endtask

   // No hint signal here, so evicting writes are sent bare
   task automatic wr(input ctd_aw_s r, input bit hold);
      aw_valid <= 1'b1;
      aw_req   <= r;
      do @(posedge clk_sys); while (aw_ready !== 1'b1);
      if (!hold) begin
         aw_valid <= 1'b0;
         aw_req   <= ~r;
      end
   endtask
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the coherent transaction type decoder
`timescale 1ns/1ps
module testbench;
   import ctd_pkg::*;

   logic       clk_sys;
   logic       rstn;
   logic       ar_valid;
   ctd_ar_s    ar_req;
   logic       ar_ready;
   logic       aw_valid;
   ctd_aw_s    aw_req;
   logic       aw_ready;
   ctd_res_s   ar_res;
   ctd_res_s   aw_res;
   logic       ar_illegal;
   logic       aw_illegal;
   logic [7:0] ill_count;
   ctd_res_s   exp_rd_q[$];
   ctd_res_s   exp_wr_q[$];
   logic [3:0] ep_rd = 4'h0;
   logic [3:0] ep_wr = 4'h0;
   logic [7:0] ill_exp = 8'h00;
   int         err_total = 0;
   int         comparisons = 0;

   ctd_top ctd_top_inst (.clk_sys(clk_sys), .rstn(rstn),
      .ar_valid(ar_valid), .ar_req(ar_req), .ar_ready(ar_ready),
      .aw_valid(aw_valid), .aw_req(aw_req), .aw_ready(aw_ready),
      .ar_res(ar_res), .aw_res(aw_res), .ar_illegal(ar_illegal),
      .aw_illegal(aw_illegal), .ill_count(ill_count));

   ctd_master ctd_master_inst (.clk_sys(clk_sys), .ar_valid(ar_valid),
      .ar_req(ar_req), .ar_ready(ar_ready), .aw_valid(aw_valid),
      .aw_req(aw_req), .aw_ready(aw_ready));

   always #50 clk_sys = ~clk_sys;

   task automatic print_verdict;
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk_res(input string n, input ctd_res_s e, input ctd_res_s g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_bit(input string n, input logic [7:0] e,
                          input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   // Expected classification; write codes arrive zero-extended
   function automatic ctd_dec_s exp_dec(input bit rd, input logic [1:0] b,
      input logic [1:0] d, input logic [3:0] s, input logic [3:0] c);
      ctd_dec_s e;
      ctd_typ_e t;
      logic     sh;
      e  = '0;
      t  = CTD_T_NONE;
      sh = (d == CTD_DOM_ISH) || (d == CTD_DOM_OSH);
      if (b[0]) begin
         if (s == 4'h0) t = CTD_T_BARRIER;
      end else if (rd) begin
         case (s)
            4'h0: t = sh ? CTD_T_RD_ONCE : CTD_T_RD_NOSNP;
            4'h1: if (sh) t = CTD_T_RD_SHARED;
            4'h2: if (sh) t = CTD_T_RD_CLEAN;
            4'h3: if (sh) t = CTD_T_RD_NSD;
            4'h7: if (sh) t = CTD_T_RD_UNIQUE;
            4'hB: if (sh) t = CTD_T_CLN_UNQ;
            4'hC: if (sh) t = CTD_T_MK_UNQ;
            4'h8: if (d != CTD_DOM_SYS) t = CTD_T_CLN_SHR;
            4'h9: if (d != CTD_DOM_SYS) t = CTD_T_CLN_INV;
            4'hD: if (d != CTD_DOM_SYS) t = CTD_T_MK_INV;
            4'hE: if (sh) t = CTD_T_DVM_CMPL;
            4'hF: if (sh) t = CTD_T_DVM_MSG;
            default: t = CTD_T_NONE;
         endcase
      end else begin
         case (s)
            4'h0: t = sh ? CTD_T_WR_UNIQUE : CTD_T_WR_NOSNP;
            4'h1: if (sh) t = CTD_T_WR_LINE_UNQ;
            4'h2: if (d != CTD_DOM_SYS) t = CTD_T_WR_CLEAN;
            4'h3: if (d != CTD_DOM_SYS) t = CTD_T_WR_COPYBACK;
            4'h4: if (sh) t = CTD_T_EVICT;
            4'h5: if (d != CTD_DOM_SYS) t = CTD_T_WR_EVICT;
            default: t = CTD_T_NONE;
         endcase
      end
      e.typ = t;
      if (t inside {CTD_T_RD_NOSNP, CTD_T_WR_NOSNP})
         e.grp = CTD_GRP_NOSNP;
      else if (t inside {[CTD_T_RD_ONCE:CTD_T_MK_UNQ], CTD_T_WR_UNIQUE,
                         CTD_T_WR_LINE_UNQ})
         e.grp = CTD_GRP_COH;
      else if (t inside {[CTD_T_CLN_SHR:CTD_T_MK_INV]})
         e.grp = CTD_GRP_CMO;
      else if (t inside {[CTD_T_WR_CLEAN:CTD_T_WR_EVICT]})
         e.grp = CTD_GRP_MEMUPD;
      else if (t == CTD_T_BARRIER)
         e.grp = CTD_GRP_BAR;
      else if (t != CTD_T_NONE)
         e.grp = CTD_GRP_DVM;
      e.illegal      = (t == CTD_T_NONE);
      e.snoop_inner  = (e.grp inside {CTD_GRP_COH, CTD_GRP_CMO}) && sh;
      e.snoop_outer  = (e.grp inside {CTD_GRP_COH, CTD_GRP_CMO}) &&
                       (d == CTD_DOM_OSH);
      e.downstream   = e.grp inside {CTD_GRP_CMO, CTD_GRP_MEMUPD};
      e.cache_lookup = !e.illegal && t != CTD_T_BARRIER && d != CTD_DOM_SYS;
      e.bar_sync     = (b == CTD_BAR_SYNC);
      e.ign_bar      = (b == CTD_BAR_NORM_IGN);
      e.attr_err     = (!c[1] && d != CTD_DOM_SYS) ||
                       (c[3:2] != 2'h0 && d == CTD_DOM_SYS);
      return e;
   endfunction

   task automatic rd(input logic [1:0] b, input logic [1:0] d,
                     input logic [3:0] s, input logic [3:0] c, input bit h);
      ctd_dec_s e;
      e = exp_dec(1'b1, b, d, s, c);
      exp_rd_q.push_back('{1'b1, e, ep_rd});
      if (e.typ == CTD_T_BARRIER) ep_rd++;
      if (e.illegal && ill_exp != 8'hFF) ill_exp++;
      ctd_master_inst.rd('{b, d, s, c}, h);
   endtask

   task automatic wr(input logic [1:0] b, input logic [1:0] d,
                     input logic [2:0] s, input logic [3:0] c, input bit h);
      ctd_dec_s e;
      e = exp_dec(1'b0, b, d, {1'b0, s}, c);
      exp_wr_q.push_back('{1'b1, e, ep_wr});
      if (e.typ == CTD_T_BARRIER) ep_wr++;
      if (e.illegal && ill_exp != 8'hFF) ill_exp++;
      ctd_master_inst.wr('{b, d, s, c}, h);
   endtask

   // One pulse per taken request, compared against the oldest expectation
   task automatic mon(input string n, ref ctd_res_s q[$], input ctd_res_s g,
                      input logic ill);
      ctd_res_s x;
      if (g.vld === 1'b1) begin
         x = (q.size() > 0) ? q.pop_front() : '0;
         chk_res(n, x, g);
         chk_bit("illegal", {7'h0, x.dec.illegal}, {7'h0, ill});
      end else begin
         chk_bit("illegal idle", 8'h00, {7'h0, ill});
      end
   endtask

   always @(negedge clk_sys) begin
      if (rstn === 1'b1) begin
         mon("ar_res", exp_rd_q, ar_res, ar_illegal);
         mon("aw_res", exp_wr_q, aw_res, aw_illegal);
      end
   end

   task automatic drain;
      repeat (3) @(posedge clk_sys);
      chk_bit("pending rd", 8'h00, 8'(exp_rd_q.size()));
      chk_bit("pending wr", 8'h00, 8'(exp_wr_q.size()));
      chk_bit("ill_count", ill_exp, ill_count);
   endtask

   task automatic scn_reset_vals;
      chk_bit("ar_ready", 8'h00, {7'h0, ar_ready});
      chk_bit("aw_ready", 8'h00, {7'h0, aw_ready});
      chk_bit("ill_count", CTD_RST_ICNT, ill_count);
      chk_res("ar_res", '0, ar_res);
      chk_res("aw_res", '0, aw_res);
   endtask

   task automatic scn_b2b;
      rd(CTD_BAR_MEMORY, CTD_DOM_ISH, 4'h0, 4'hF, 1'b1);
      rd(CTD_BAR_NORM_RESP, CTD_DOM_OSH, 4'h1, 4'hF, 1'b1);
      rd(CTD_BAR_NORM_RESP, CTD_DOM_ISH, 4'h7, 4'hF, 1'b0);
      @(posedge clk_sys);
      // Both channels illegal in one cycle: count steps by two
      fork
         rd(CTD_BAR_NORM_RESP, CTD_DOM_SYS, 4'h5, 4'h2, 1'b0);
         wr(CTD_BAR_SYNC, CTD_DOM_NSH, 3'h4, 4'h2, 1'b0);
      join
      drain();
   endtask

   task automatic scn_rd_sweep;
      for (int i = 0; i < 256; i++) begin
         rd(i[7:6], i[5:4], i[3:0], {i[1:0], i[5:4]}, 1'b0);
         @(posedge clk_sys);
      end
      drain();
   endtask

   task automatic scn_wr_sweep;
      for (int i = 0; i < 128; i++) begin
         wr(i[6:5], i[4:3], i[2:0], {i[1:0], i[4:3]}, 1'b0);
         @(posedge clk_sys);
      end
      drain();
   endtask

   // Saturated count and advanced epochs must clear on a mid-run reset
   task automatic scn_rst;
      rstn <= 1'b0;
      @(negedge clk_sys);
      scn_reset_vals();
      @(posedge clk_sys);
      rstn <= 1'b1;
      ep_rd   = CTD_RST_EPOCH;
      ep_wr   = CTD_RST_EPOCH;
      ill_exp = CTD_RST_ICNT;
      repeat (2) @(posedge clk_sys);
      wr(CTD_BAR_MEMORY, CTD_DOM_SYS, 3'h0, 4'h2, 1'b1);
      wr(CTD_BAR_NORM_IGN, CTD_DOM_SYS, 3'h0, 4'h2, 1'b0);
      drain();
   endtask

   initial begin
      #(4000 * 100);
      err_total++;
      print_verdict();
   end

   initial begin
      clk_sys = 1'b0;
      rstn    = 1'b0;
      repeat (12) @(posedge clk_sys);
      scn_reset_vals();
      rstn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk_bit("ar_ready", 8'h01, {7'h0, ar_ready});
      chk_bit("aw_ready", 8'h01, {7'h0, aw_ready});
      scn_b2b();
      scn_rd_sweep();
      scn_wr_sweep();
      scn_rst();
      print_verdict();
   end
endmodule
